//--- dv/spec_reg_model.sv
/*
 Register file model standing at the decoder's far side.
 Assumes the bench drives the specifier bytes and presets; write-back lands on each clock edge where reg_wr_en is high.
*/
`timescale 1ns/1ns
module spec_reg_model (
	// Clock
	input  wire logic        core_clk,
	// Specifier bytes
	input  wire logic [7:0]  spec_byte,
	input  wire logic [7:0]  base_byte,
	// Write-back
	input  wire logic        reg_wr_en,
	input  wire logic [3:0]  reg_wr_num,
	input  wire logic [31:0] reg_wr_data,
	// Preset from the bench
	input  wire logic        preset_en,
	input  wire logic [3:0]  preset_num,
	input  wire logic [31:0] preset_data,
	// Read values
	output logic      [31:0] index_val,
	output logic      [31:0] base_val
);
	logic [31:0] regs [16] = '{default: 32'h0};

	// Indexed forms take the base register from the second byte
	always_comb begin
		index_val = regs[spec_byte[3:0]];
		base_val  = (spec_byte[7:4] == 4'h4) ? regs[base_byte[3:0]] : regs[spec_byte[3:0]];
	end
	always @(posedge core_clk) begin
		if (reg_wr_en) begin
			regs[reg_wr_num] <= reg_wr_data;
		end
		if (preset_en) begin
			regs[preset_num] <= preset_data;
		end
	end
endmodule

//--- dv/testbench.sv
/*
 Self-checking bench for the operand specifier mode decoder.
 Assumes the register model and the package are compiled first.
*/
`timescale 1ns/1ns
module testbench;
	import opspec_pkg::*;
	logic        core_clk, rst_n, spec_valid, field_wide, result_valid, is_literal;
	logic        deferred, indexed, reserved_fault, unpredictable, reg_wr_en;
	logic [7:0]  spec_byte, base_byte;
	logic [31:0] disp_ext, index_val, base_val, operand_addr, reg_wr_data;
	logic [5:0]  literal_value;
	logic [3:0]  reg_wr_num, preset_num;
	logic [31:0] preset_data;
	logic        preset_en;
	access_t     access_type;
	dsize_t      data_size;
	amode_t      addr_mode;
	int          num_errors, n_checks, cycles;

	operand_specifier_mode_decoder u_dut (.core_clk(core_clk), .rst_n(rst_n),
		.spec_valid(spec_valid), .spec_byte(spec_byte), .base_byte(base_byte),
		.disp_ext(disp_ext), .access_type(access_type), .data_size(data_size),
		.field_wide(field_wide), .named_general_register(index_val),
		.base_reg_value(base_val), .result_valid(result_valid), .addr_mode(addr_mode),
		.operand_addr(operand_addr), .literal_value(literal_value), .is_literal(is_literal),
		.deferred(deferred), .indexed(indexed), .reserved_fault(reserved_fault),
		.unpredictable(unpredictable), .reg_wr_en(reg_wr_en), .reg_wr_num(reg_wr_num),
		.reg_wr_data(reg_wr_data));
	spec_reg_model u_regs (.core_clk(core_clk), .spec_byte(spec_byte), .base_byte(base_byte),
		.reg_wr_en(reg_wr_en), .reg_wr_num(reg_wr_num), .reg_wr_data(reg_wr_data),
		.preset_en(preset_en), .preset_num(preset_num), .preset_data(preset_data),
		.index_val(index_val), .base_val(base_val));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// One idle edge first so a pending write-back cannot overwrite the preset
	task automatic set_reg(input int n, input logic [31:0] v);
		@(posedge core_clk);
		preset_en   <= 1'b1;
		preset_num  <= 4'(n);
		preset_data <= v;
		@(posedge core_clk);
		preset_en <= 1'b0;
	endtask

	// Answer is checked 1 ns after the taking edge
	task automatic issue(input logic [7:0] sb, input logic [7:0] bb, input logic [31:0] d,
		input access_t a, input dsize_t s, input logic fw);
		@(posedge core_clk);
		spec_valid  <= 1'b1;
		spec_byte   <= sb;
		base_byte   <= bb;
		disp_ext    <= d;
		access_type <= a;
		data_size   <= s;
		field_wide  <= fw;
		@(posedge core_clk);
		spec_valid <= 1'b0;
		#1;
		check("result_valid", 32'(result_valid), 32'h1);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_step();
		set_reg(3, 32'h0000_0100);
		issue(8'h73, 8'h00, 32'h0, ACC_READ, SIZE_LONG, 1'b0);
		check("dec_addr", operand_addr, 32'h0000_00FC);
		check("dec_wb", reg_wr_data, 32'h0000_00FC);
		check("dec_num", 32'(reg_wr_num), 32'h3);
		check("dec_we", 32'(reg_wr_en), 32'h1);
		issue(8'h83, 8'h00, 32'h0, ACC_READ, SIZE_WORD, 1'b0);
		check("inc_addr", operand_addr, 32'h0000_00FC);
		check("inc_wb", reg_wr_data, 32'h0000_00FE);
		issue(8'h93, 8'h00, 32'h0, ACC_READ, SIZE_BYTE, 1'b0);
		check("incdf_wb", reg_wr_data, 32'h0000_0102);
		check("incdf_def", 32'(deferred), 32'h1);
		issue(8'h83, 8'h00, 32'h0, ACC_READ, SIZE_OCTA, 1'b0);
		check("inc_octa", reg_wr_data, 32'h0000_0112);
	endtask

	task automatic t_literal();
		logic [7:0] bases [3] = '{8'h05, 8'h52, 8'h43};
		for (int i = 0; i < 5; i++) begin
			issue({2'b00, 2'(i), 4'h5}, 8'h00, 32'h0, access_t'(i), SIZE_LONG, 1'b0);
			check("lit_fault", 32'(reserved_fault), 32'(i != 0));
			check("lit_wr", 32'(reg_wr_en), 32'h0);
		end
		issue(8'h25, 8'h00, 32'h0, ACC_READ, SIZE_LONG, 1'b0);
		check("lit_val", 32'({is_literal, literal_value}), 32'h0000_0065);
		check("lit_mode", 32'(addr_mode), 32'(AM_LITERAL));
		foreach (bases[i]) begin
			issue(8'h41, bases[i], 32'h0, ACC_READ, SIZE_LONG, 1'b0);
			check("idx_base_fault", 32'(reserved_fault), 32'h1);
		end
	endtask

	task automatic t_index();
		set_reg(2, 32'h0000_0003);
		set_reg(6, 32'h0000_1000);
		issue(8'h42, 8'h66, 32'h0, ACC_READ, SIZE_LONG, 1'b0);
		check("idx_addr", operand_addr, 32'h0000_100C);
		check("idx_flags", 32'({indexed, reserved_fault}), 32'h2);
		issue(8'h4F, 8'h66, 32'h0, ACC_READ, SIZE_LONG, 1'b0);
		check("idx_pc", 32'(reserved_fault), 32'h1);
		issue(8'h46, 8'h86, 32'h0, ACC_READ, SIZE_LONG, 1'b0);
		check("idx_same", 32'(unpredictable), 32'h1);
		issue(8'h42, 8'h76, 32'h0, ACC_READ, SIZE_LONG, 1'b0);
		check("idx_diff", 32'(unpredictable), 32'h0);
	endtask

	task automatic t_sp();
		issue(8'h5E, 8'h00, 32'h0, ACC_READ, SIZE_QUAD, 1'b0);
		check("sp_quad", 32'(unpredictable), 32'h1);
		issue(8'h5E, 8'h00, 32'h0, ACC_READ, SIZE_LONG, 1'b0);
		check("sp_long", 32'(unpredictable), 32'h0);
		issue(8'h5E, 8'h00, 32'h0, ACC_FIELD, SIZE_LONG, 1'b1);
		check("sp_field", 32'(unpredictable), 32'h1);
		issue(8'h52, 8'h00, 32'h0, ACC_ADDR, SIZE_LONG, 1'b0);
		check("reg_addr", 32'(reserved_fault), 32'h1);
	endtask

	task automatic t_modes();
		amode_t gen [11] = '{AM_REG, AM_REGDEF, AM_AUTODEC, AM_AUTOINC, AM_AUTOINCD,
			AM_DISP, AM_DISPDEF, AM_DISP, AM_DISPDEF, AM_DISP, AM_DISPDEF};
		amode_t pcm [8] = '{AM_IMMED, AM_ABSOLUTE, AM_REL, AM_RELDEF,
			AM_REL, AM_RELDEF, AM_REL, AM_RELDEF};
		for (int m = 5; m < 16; m++) begin
			issue({4'(m), 4'h2}, 8'h00, 32'h0, ACC_READ, SIZE_LONG, 1'b0);
			check("gen_mode", 32'(addr_mode), 32'(gen[m-5]));
		end
		for (int m = 8; m < 16; m++) begin
			issue({4'(m), 4'hF}, 8'h00, 32'h0, ACC_READ, SIZE_LONG, 1'b0);
			check("pc_mode", 32'(addr_mode), 32'(pcm[m-8]));
		end
	endtask

	task automatic t_disp();
		set_reg(2, 32'h0000_1000);
		issue(8'hA2, 8'h00, 32'h0000_0080, ACC_READ, SIZE_LONG, 1'b0);
		check("bdisp", operand_addr, 32'h0000_0F80);
		issue(8'hC2, 8'h00, 32'h0000_8000, ACC_READ, SIZE_LONG, 1'b0);
		check("wdisp", operand_addr, 32'hFFFF_9000);
		issue(8'hE2, 8'h00, 32'h0000_8000, ACC_READ, SIZE_LONG, 1'b0);
		check("ldisp", operand_addr, 32'h0000_9000);
	endtask

	// Mid-run reset must clear the held result and fault flags
	task automatic t_reset();
		issue(8'h25, 8'h00, 32'h0, ACC_WRITE, SIZE_LONG, 1'b0);
		check("pre_rst_fault", 32'(reserved_fault), 32'h1);
		@(posedge core_clk);
		rst_n <= 1'b0;
		@(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		check("rst_flags", 32'({reserved_fault, unpredictable, is_literal}), 32'h0);
		check("rst_lit", 32'({indexed, deferred, literal_value}), 32'h0);
		check("rst_addr", operand_addr, 32'h0);
		issue(8'h25, 8'h00, 32'h0, ACC_READ, SIZE_LONG, 1'b0);
		check("post_rst_lit", 32'({is_literal, literal_value}), 32'h0000_0065);
		check("post_rst_flt", 32'(reserved_fault), 32'h0);
	endtask

	// ----------------------------------------
	// Clock, reset, sequence, timeout
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			finish_test();
		end
	end

	initial begin
		{rst_n, spec_valid, field_wide, spec_byte, base_byte, disp_ext} = '0;
		{preset_en, preset_num, preset_data} = '0;
		access_type = ACC_READ;
		data_size   = SIZE_BYTE;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		check("rst_out", 32'({result_valid, reg_wr_en, addr_mode}), 32'h0);
		t_step();
		t_literal();
		t_index();
		t_sp();
		t_modes();
		t_disp();
		t_reset();
		finish_test();
	end
endmodule

//--- rtl/operand_specifier_mode_decoder.sv
/*
 Operand specifier mode decoder: classifies each general specifier,
 checks it against access and data type, forms the operand address and
 the register write-back for the stepping modes.
 Assumes the fetch unit presents the first specifier byte, any extension
 (displacement, base byte) and the register file contents in the same
 cycle as spec_valid, and that spec_valid is held off while busy.
*/
// Notes on behaviour
// - Mode 0-3 literal, 4 indexed, 5 reg, 6 deferred, 7-9 auto, A-F displacement.
// - Literal allowed only for read access; otherwise reserved mode fault.
// - Literal, register or indexed base under an index raises the fault.
// - Literal takes its value from the specifier; no register touched.
// - Autodecrement subtracts size, writes back, uses new value as address.
// - Literal, register, register deferred, autodecrement and immediate checked against access type or register; fault or unpredictable.
// - Register mode on stack pointer unpredictable for wide data or wide field.
// - Auto-stepping base with index equal to base register is unpredictable.
// - With program counter, modes 8, 9, A-F become immediate, absolute, relative.
// - Autoincrement uses register as address, then adds operand size.
// - Autoincrement deferred reads pointer, then adds four to the register.
// - Byte and word displacements are sign-extended to 32 bits.
// - Index scaled by size and added to base address; PC index faults.
`timescale 1ns/1ns
`include "opspec_params.svh"

module operand_specifier_mode_decoder import opspec_pkg::*; #(
	parameter int ADDR_W = 32
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	// Specifier from fetch
	input  wire logic              spec_valid,
	input  wire logic [7:0]        spec_byte,
	input  wire logic [7:0]        base_byte,
	input  wire logic [31:0]       disp_ext,
	input  wire access_t           access_type,
	input  wire dsize_t            data_size,
	input  wire logic              field_wide,
	// Register file read values
	input  wire logic [ADDR_W-1:0] named_general_register,
	input  wire logic [ADDR_W-1:0] base_reg_value,
	// Result to operand stage
	output logic                   result_valid,
	output amode_t                 addr_mode,
	output logic [ADDR_W-1:0]      operand_addr,
	output logic [5:0]             literal_value,
	output logic                   is_literal,
	output logic                   deferred,
	output logic                   indexed,
	output logic                   reserved_fault,
	output logic                   unpredictable,
	// Register write-back
	output logic                   reg_wr_en,
	output logic [3:0]             reg_wr_num,
	output logic [ADDR_W-1:0]      reg_wr_data
);
	// Address arithmetic and displacement extension are fixed at 32 bits
	if (ADDR_W != 32) begin : g_width_check
		$error("operand_specifier_mode_decoder: ADDR_W must be 32");
	end

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic logic [ADDR_W-1:0] size_bytes(input dsize_t s);
		case (s)
			SIZE_BYTE: size_bytes = ADDR_W'(1);
			SIZE_WORD: size_bytes = ADDR_W'(2);
			SIZE_LONG: size_bytes = ADDR_W'(4);
			SIZE_QUAD: size_bytes = ADDR_W'(8);
			SIZE_OCTA: size_bytes = ADDR_W'(16);
			default:   size_bytes = ADDR_W'(4);
		endcase
	endfunction

	function automatic amode_t classify(input logic [3:0] m, input logic [3:0] r);
		logic pc;
		pc = (r == `REG_PC);
		if (m <= `MODE_LIT_MAX) classify = AM_LITERAL;
		else case (m)
			`MODE_REG:       classify = AM_REG;
			`MODE_REGDEF:    classify = AM_REGDEF;
			`MODE_AUTODEC:   classify = AM_AUTODEC;
			`MODE_AUTOINC:   classify = pc ? AM_IMMED : AM_AUTOINC;
			`MODE_AUTOINCDF: classify = pc ? AM_ABSOLUTE : AM_AUTOINCD;
			`MODE_BDISP, `MODE_WDISP, `MODE_LDISP:
				classify = pc ? AM_REL : AM_DISP;
			`MODE_BDISPDF, `MODE_WDISPDF, `MODE_LDISPDF:
				classify = pc ? AM_RELDEF : AM_DISPDEF;
			default:         classify = AM_BAD;
		endcase
	endfunction

	// Sign-extended displacement by mode width
	function automatic logic [31:0] disp32(input logic [3:0] m, input logic [31:0] d);
		case (m)
			`MODE_BDISP, `MODE_BDISPDF: disp32 = {{24{d[7]}}, d[7:0]};
			`MODE_WDISP, `MODE_WDISPDF: disp32 = {{16{d[15]}}, d[15:0]};
			default:                    disp32 = d;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Combinational decode of the current specifier
	// ------------------------------------------------------------
	logic [3:0]        p_mode;
	logic [3:0]        p_reg;
	logic              is_idx;
	logic [3:0]        b_mode;
	logic [3:0]        b_reg;
	amode_t            b_class;
	logic [ADDR_W-1:0] sz;
	logic [ADDR_W-1:0] ea;
	logic [ADDR_W-1:0] wb;
	logic              wb_en;
	logic              flt;
	logic              unp;
	logic              wide;

	assign p_mode  = spec_byte[`MODE_HI:`MODE_LO];
	assign p_reg   = spec_byte[`REG_HI:`REG_LO];
	assign is_idx  = (p_mode == `MODE_INDEX);
	assign b_mode  = is_idx ? base_byte[`MODE_HI:`MODE_LO] : p_mode;
	assign b_reg   = is_idx ? base_byte[`REG_HI:`REG_LO] : p_reg;
	assign b_class = classify(b_mode, b_reg);
	assign sz      = size_bytes(data_size);
	assign wide    = (data_size == SIZE_QUAD) || (data_size == SIZE_OCTA);

	always_comb begin
		ea    = base_reg_value;
		wb    = base_reg_value;
		wb_en = 1'b0;
		flt   = 1'b0;
		unp   = 1'b0;
		case (b_class)
			AM_LITERAL: begin
				ea = '0;
				if (access_type != ACC_READ) flt = 1'b1;
				if (is_idx) flt = 1'b1;
			end
			AM_REG: begin
				if (access_type == ACC_ADDR) flt = 1'b1;
				if (is_idx) flt = 1'b1;
				if (b_reg == `REG_PC) unp = 1'b1;
				if (b_reg == `REG_SP && (wide || (access_type == ACC_FIELD && field_wide)))
					unp = 1'b1;
			end
			AM_REGDEF: begin
				if (b_reg == `REG_PC) unp = 1'b1;
			end
			AM_AUTODEC: begin
				wb    = base_reg_value - sz;
				ea    = wb;
				wb_en = 1'b1;
				if (b_reg == `REG_PC) unp = 1'b1;
			end
			AM_AUTOINC, AM_IMMED: begin
				wb    = base_reg_value + sz;
				wb_en = 1'b1;
				if (b_class == AM_IMMED && (access_type == ACC_MODIFY || access_type == ACC_WRITE))
					unp = 1'b1;
			end
			AM_AUTOINCD, AM_ABSOLUTE: begin
				wb    = base_reg_value + `PTR_STEP;
				wb_en = 1'b1;
			end
			AM_DISP, AM_DISPDEF, AM_REL, AM_RELDEF: begin
				ea = base_reg_value + disp32(b_mode, disp_ext);
			end
			default: flt = 1'b1;
		endcase
		if (is_idx) begin
			if (b_mode == `MODE_INDEX) flt = 1'b1;
			if (p_reg == `REG_PC) flt = 1'b1;
			if ((b_class == AM_AUTODEC || b_class == AM_AUTOINC || b_class == AM_AUTOINCD)
				&& p_reg == b_reg)
				unp = 1'b1;
			ea = ea + (named_general_register << data_size);
		end
		if (flt)
			wb_en = 1'b0;
	end

	// ------------------------------------------------------------
	// Result registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			result_valid   <= 1'b0;
			addr_mode      <= AM_LITERAL;
			operand_addr   <= '0;
			literal_value  <= 6'h00;
			is_literal     <= 1'b0;
			deferred       <= 1'b0;
			indexed        <= 1'b0;
			reserved_fault <= 1'b0;
			unpredictable  <= 1'b0;
		end else begin
			result_valid   <= spec_valid;
			if (spec_valid) begin
				addr_mode      <= b_class;
				operand_addr   <= ea;
				literal_value  <= spec_byte[5:0];
				is_literal     <= (b_class == AM_LITERAL);
				deferred       <= b_class inside {AM_AUTOINCD, AM_DISPDEF, AM_ABSOLUTE, AM_RELDEF};
				indexed        <= is_idx;
				reserved_fault <= flt;
				unpredictable  <= unp;
			end
		end
	end

	// Write-back is a one-cycle pulse; suppressed on fault so a retry is clean
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			reg_wr_en   <= 1'b0;
			reg_wr_num  <= 4'h0;
			reg_wr_data <= '0;
		end else begin
			reg_wr_en   <= spec_valid && wb_en;
			reg_wr_num  <= b_reg;
			reg_wr_data <= wb;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	lit_access_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		spec_valid && spec_byte[7:6] == 2'b00 && access_type != ACC_READ
		|=> reserved_fault)
		else $error("literal with non-read access did not fault");

	lit_no_reg_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		spec_valid && spec_byte[7:6] == 2'b00 |=> !reg_wr_en && is_literal)
		else $error("literal touched a register");

	idx_base_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		spec_valid && is_idx && (base_byte[7:4] <= `MODE_REG) |=> reserved_fault)
		else $error("bad index base did not fault");

	autodec_wb_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		spec_valid && !is_idx && p_mode == `MODE_AUTODEC
		|=> reg_wr_en && reg_wr_data == operand_addr
		&& reg_wr_data == $past(base_reg_value) - $past(sz))
		else $error("autodecrement write-back wrong");

	autoinc_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		spec_valid && !is_idx && p_mode == `MODE_AUTOINC
		|=> reg_wr_en && operand_addr == $past(base_reg_value)
		&& reg_wr_data == $past(base_reg_value) + $past(sz))
		else $error("autoincrement step wrong");

	incdef_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		spec_valid && !is_idx && p_mode == `MODE_AUTOINCDF
		|=> reg_wr_en && reg_wr_data == $past(base_reg_value) + `PTR_STEP)
		else $error("autoincrement deferred step not four");

	sp_wide_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		spec_valid && spec_byte == {`MODE_REG, `REG_SP} && wide |=> unpredictable)
		else $error("wide stack pointer register mode not flagged");

	idx_same_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		spec_valid && is_idx && base_byte[7:4] inside {`MODE_AUTODEC, `MODE_AUTOINC}
		&& base_byte[3:0] == p_reg && base_byte[3:0] != `REG_PC |=> unpredictable)
		else $error("index equals stepped base not flagged");

	pc_index_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		spec_valid && is_idx && p_reg == `REG_PC |=> reserved_fault && !reg_wr_en)
		else $error("program counter index did not fault");

	pc_immed_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		spec_valid && spec_byte == {`MODE_AUTOINC, `REG_PC} |=> addr_mode == AM_IMMED)
		else $error("immediate not decoded");
endmodule

//--- rtl/opspec_params.svh
/*
 Constant macros for the operand specifier mode decoder: field positions,
 mode codes, special register numbers and fixed step sizes.
 Assumes inclusion by bare name from the decoder module.
*/
`ifndef OPSPEC_PARAMS_SVH
`define OPSPEC_PARAMS_SVH

`define MODE_HI        7
`define MODE_LO        4
`define REG_HI         3
`define REG_LO         0
`define MODE_LIT_MAX   4'h3
`define MODE_INDEX     4'h4
`define MODE_REG       4'h5
`define MODE_REGDEF    4'h6
`define MODE_AUTODEC   4'h7
`define MODE_AUTOINC   4'h8
`define MODE_AUTOINCDF 4'h9
`define MODE_BDISP     4'hA
`define MODE_BDISPDF   4'hB
`define MODE_WDISP     4'hC
`define MODE_WDISPDF   4'hD
`define MODE_LDISP     4'hE
`define MODE_LDISPDF   4'hF
`define REG_PC         4'hF
`define REG_SP         4'hE
`define PTR_STEP       32'h0000_0004
`define FIELD_LIMIT    7'h20

`endif

//--- rtl/opspec_pkg.sv
/*
 Types shared by the operand specifier mode decoder.
 Assumes the params header sits beside it on the include path.
*/
package opspec_pkg;
	typedef enum logic [2:0] {
		ACC_READ   = 3'h0,
		ACC_MODIFY = 3'h1,
		ACC_WRITE  = 3'h2,
		ACC_FIELD  = 3'h3,
		ACC_ADDR   = 3'h4
	} access_t;

	typedef enum logic [2:0] {
		SIZE_BYTE  = 3'h0,
		SIZE_WORD  = 3'h1,
		SIZE_LONG  = 3'h2,
		SIZE_QUAD  = 3'h3,
		SIZE_OCTA  = 3'h4
	} dsize_t;

	typedef enum logic [4:0] {
		AM_LITERAL  = 5'h00,
		AM_REG      = 5'h01,
		AM_REGDEF   = 5'h02,
		AM_AUTODEC  = 5'h03,
		AM_AUTOINC  = 5'h04,
		AM_AUTOINCD = 5'h05,
		AM_DISP     = 5'h06,
		AM_DISPDEF  = 5'h07,
		AM_IMMED    = 5'h08,
		AM_ABSOLUTE = 5'h09,
		AM_REL      = 5'h0A,
		AM_RELDEF   = 5'h0B,
		AM_BAD      = 5'h1F
	} amode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BASE = 3'b010,
		ST_DONE = 3'b100
	} dstate_t;
endpackage
